// *** adc_end_flag_control.sv ***
// The AXI4-Lite register port and the register addresses were left to the implementer.
`timescale 1ns/1ns
// Notes on behaviour
// - single mode: channel finished sets done flag
// - scan mode: flag set after whole group
// - software clears flag only by write-zero after reading one
// - transfer controller result read clears flag while the done interrupt is raised
// - interrupt enable is bit six, resets zero
// - done interrupt only while enable is one
// - scan bit picks single or scan mode
// - single clears start; scan runs until cleared
module adc_end_flag_control #(
  parameter int CONV_CYCLES = adc_flag_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // axi4-lite slave
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // analog front end
  input  wire logic [9:0]  i_adc_data,
  output logic [3:0]       o_adc_chan,
  // data transfer controller
  input  wire logic        i_dtc_result_read,
  // interrupts
  output logic             o_conversion_done_irq,
  output logic             o_irq
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  logic                       conversion_done_flag, next_conversion_done_flag;
  logic                       done_irq_enable, next_done_irq_enable;
  logic                       conversion_start_bit, next_conversion_start_bit;
  logic                       scan_mode, next_scan_mode;
  logic [3:0]                 chan, next_chan;
  logic                       flag_read_seen, next_flag_read_seen;
  logic [adc_flag_pkg::EV_W-1:0] ev_stat, next_ev_stat;
  logic [adc_flag_pkg::EV_W-1:0] ev_mask, next_ev_mask;
  logic                       done_irq, next_done_irq;
  logic                       irq, next_irq;
  logic [3:0]                 adc_chan, next_adc_chan;
  logic [9:0]                 data_meta, data_sync;
  logic [9:0]                 result [4];
  logic                       ch_done, all_done, busy;
  logic [1:0]                 slot;
  logic                       csr_wr, csr_rd, sw_clear, dtc_clear;
  logic [7:0]                 csr_val;

  reg_access_if rif ();

  // ----------------------------------------------------------------
  // submodules
  // ----------------------------------------------------------------
  axil_reg_slave u_bus (
    .i_mclk    (i_mclk),
    .i_rst     (i_rst),
    .i_awaddr  (i_awaddr),
    .i_awvalid (i_awvalid),
    .o_awready (o_awready),
    .i_wdata   (i_wdata),
    .i_wstrb   (i_wstrb),
    .i_wvalid  (i_wvalid),
    .o_wready  (o_wready),
    .o_bresp   (o_bresp),
    .o_bvalid  (o_bvalid),
    .i_bready  (i_bready),
    .i_araddr  (i_araddr),
    .i_arvalid (i_arvalid),
    .o_arready (o_arready),
    .o_rdata   (o_rdata),
    .o_rresp   (o_rresp),
    .o_rvalid  (o_rvalid),
    .i_rready  (i_rready),
    .rif       (rif.bus)
  );

  conv_sequencer #(.CONV_CYCLES(CONV_CYCLES)) u_seq (
    .i_mclk     (i_mclk),
    .i_rst      (i_rst),
    .i_start    (conversion_start_bit),
    .i_scan     (scan_mode),
    .i_chan     (chan),
    .o_ch_done  (ch_done),
    .o_all_done (all_done),
    .o_slot     (slot),
    .o_busy     (busy)
  );

  // ----------------------------------------------------------------
  // register decode
  // ----------------------------------------------------------------
  assign csr_val = {conversion_done_flag, done_irq_enable, conversion_start_bit,
                    scan_mode, chan};
  assign csr_wr  = rif.wr_en && rif.wr_addr == adc_flag_pkg::CSR_OFFSET && rif.wr_strb[0];
  assign csr_rd  = rif.rd_en && rif.rd_addr == adc_flag_pkg::CSR_OFFSET;

  // only a zero written after the one was seen counts as a clear
  assign sw_clear  = csr_wr && !rif.wr_data[adc_flag_pkg::FLAG_BIT]
                     && flag_read_seen;
  // the transfer controller only runs on the request, so gate by it
  assign dtc_clear = i_dtc_result_read && done_irq;

  // read mux; unmapped addresses answer with an error and zero data
  always_comb begin
    rif.rd_data = 32'h00000000;
    rif.rd_err  = 1'b0;
    unique case (rif.rd_addr)
      adc_flag_pkg::CSR_OFFSET:      rif.rd_data = {24'h000000, csr_val};
      adc_flag_pkg::IRQ_STAT_OFFSET: rif.rd_data = {30'h00000000, ev_stat};
      adc_flag_pkg::IRQ_MASK_OFFSET: rif.rd_data = {30'h00000000, ev_mask};
      8'h04, 8'h08, 8'h0C, 8'h10: begin
        rif.rd_data = {16'h0000, result[rif.rd_addr[3:2] - 2'h1], 6'h00};
      end
      default: rif.rd_err = 1'b1;
    endcase
  end

  always_comb begin
    unique case (rif.wr_addr)
      adc_flag_pkg::CSR_OFFSET, adc_flag_pkg::IRQ_STAT_OFFSET,
      adc_flag_pkg::IRQ_MASK_OFFSET, 8'h04, 8'h08, 8'h0C, 8'h10: rif.wr_err = 1'b0;
      default:                                                     rif.wr_err = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // control/status next state
  // ----------------------------------------------------------------
  always_comb begin
    next_conversion_done_flag = conversion_done_flag;
    next_done_irq_enable      = done_irq_enable;
    next_conversion_start_bit = conversion_start_bit;
    next_scan_mode            = scan_mode;
    next_chan                 = chan;
    next_flag_read_seen       = flag_read_seen;
    next_ev_stat              = ev_stat;
    next_ev_mask              = ev_mask;
    // the read half of the clear sequence
    if (csr_rd && conversion_done_flag) begin
      next_flag_read_seen = 1'b1;
    end
    if (csr_wr) begin
      next_done_irq_enable      = rif.wr_data[adc_flag_pkg::IE_BIT];
      next_conversion_start_bit = rif.wr_data[adc_flag_pkg::START_BIT];
      next_scan_mode            = rif.wr_data[adc_flag_pkg::SCAN_BIT];
      next_chan                 = rif.wr_data[adc_flag_pkg::CHAN_LSB +: adc_flag_pkg::CHAN_W];
      next_flag_read_seen       = 1'b0;
    end else if (all_done && !scan_mode) begin
      next_conversion_start_bit = 1'b0;
    end
    if (sw_clear || dtc_clear) begin
      next_conversion_done_flag = 1'b0;
      next_flag_read_seen       = 1'b0;
    end
    // a completion in the same cycle as a clear wins
    if (all_done) begin
      next_conversion_done_flag = 1'b1;
      next_flag_read_seen       = 1'b0;
      next_ev_stat[adc_flag_pkg::EV_END_BIT] = 1'b1;
      if (conversion_done_flag && !(sw_clear || dtc_clear)) begin
        next_ev_stat[adc_flag_pkg::EV_OVERRUN_BIT] = 1'b1;
      end
    end
    // write one to clear; an event in the same cycle is kept
    if (rif.wr_en && rif.wr_addr == adc_flag_pkg::IRQ_STAT_OFFSET && rif.wr_strb[0]) begin
      next_ev_stat = ev_stat & ~rif.wr_data[adc_flag_pkg::EV_W-1:0];
      if (all_done) begin
        next_ev_stat[adc_flag_pkg::EV_END_BIT] = 1'b1;
      end
      if (all_done && conversion_done_flag && !(sw_clear || dtc_clear)) begin
        next_ev_stat[adc_flag_pkg::EV_OVERRUN_BIT] = 1'b1;
      end
    end
    if (rif.wr_en && rif.wr_addr == adc_flag_pkg::IRQ_MASK_OFFSET && rif.wr_strb[0]) begin
      next_ev_mask = rif.wr_data[adc_flag_pkg::EV_W-1:0];
    end
  end

  // done and status outputs are registered copies of the next state, so they never lag it; in scan, o_adc_chan registers the current slot, one clock behind
  assign next_done_irq = next_conversion_done_flag && next_done_irq_enable;
  assign next_irq      = |(next_ev_stat & next_ev_mask);
  assign next_adc_chan = next_scan_mode ? {next_chan[3:2], slot} : next_chan;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      conversion_done_flag <= adc_flag_pkg::CSR_RESET[adc_flag_pkg::FLAG_BIT];
      done_irq_enable      <= adc_flag_pkg::CSR_RESET[adc_flag_pkg::IE_BIT];
      conversion_start_bit <= adc_flag_pkg::CSR_RESET[adc_flag_pkg::START_BIT];
      scan_mode            <= adc_flag_pkg::CSR_RESET[adc_flag_pkg::SCAN_BIT];
      chan                 <= adc_flag_pkg::CSR_RESET[3:0];
      flag_read_seen       <= 1'b0;
      ev_stat              <= '0;
      ev_mask              <= adc_flag_pkg::MASK_RESET;
      done_irq             <= 1'b0;
      irq                  <= 1'b0;
      adc_chan             <= 4'h0;
    end else begin
      conversion_done_flag <= next_conversion_done_flag;
      done_irq_enable      <= next_done_irq_enable;
      conversion_start_bit <= next_conversion_start_bit;
      scan_mode            <= next_scan_mode;
      chan                 <= next_chan;
      flag_read_seen       <= next_flag_read_seen;
      ev_stat              <= next_ev_stat;
      ev_mask              <= next_ev_mask;
      done_irq             <= next_done_irq;
      irq                  <= next_irq;
      adc_chan             <= next_adc_chan;
    end
  end

  assign o_conversion_done_irq = done_irq;
  assign o_irq                 = irq;
  assign o_adc_chan            = adc_chan;

  // ----------------------------------------------------------------
  // result capture
  // ----------------------------------------------------------------
  // converter output is outside this clock, so two flops before use
  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      data_meta <= 10'h000;
      data_sync <= 10'h000;
    end else begin
      data_meta <= i_adc_data;
      data_sync <= data_meta;
    end
  end

  for (genvar g = 0; g < 4; g++) begin : g_result
    always_ff @(posedge i_mclk or posedge i_rst) begin
      if (i_rst) begin
        result[g] <= 10'h000;
      end else if (ch_done && slot == 2'(g)) begin
        result[g] <= data_sync;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  a_single_sets_flag: assert property (ch_done && !scan_mode |=> conversion_done_flag)
    else $error("single conversion did not set flag");
  a_flag_only_group: assert property ($rose(conversion_done_flag) |-> $past(all_done))
    else $error("flag set without group end");
  a_clear_needs_read: assert property (
    $fell(conversion_done_flag) && !$past(dtc_clear) |-> $past(flag_read_seen))
    else $error("flag cleared without prior read");
  a_dtc_clears: assert property (dtc_clear && !all_done |=> !conversion_done_flag)
    else $error("transfer read did not clear flag");
  a_ie_written: assert property (
    csr_wr |=> done_irq_enable == $past(rif.wr_data[adc_flag_pkg::IE_BIT]))
    else $error("interrupt enable not stored");
  a_irq_gated: assert property (!done_irq_enable |-> !o_conversion_done_irq)
    else $error("done interrupt while disabled");
  a_scan_selects: assert property (ch_done && !scan_mode |-> all_done)
    else $error("single mode channel did not end operation");
  a_single_stops: assert property (all_done && !scan_mode && !csr_wr
    |=> !conversion_start_bit ##1 !busy)
    else $error("start not cleared after single conversion");
  a_scan_runs_on: assert property (all_done && scan_mode && !csr_wr |=> conversion_start_bit)
    else $error("scan stopped by itself");
  a_irq_follows: assert property (
    o_conversion_done_irq == (conversion_done_flag && done_irq_enable))
    else $error("done interrupt disagrees with flag and enable");
  a_status_irq: assert property (o_irq == |(ev_stat & ev_mask))
    else $error("interrupt line disagrees with status");

  c_single_done: cover property (all_done && !scan_mode);
  c_scan_done:   cover property (all_done && scan_mode && chan[1:0] == 2'h3);
  c_sw_clear:    cover property (sw_clear ##1 !conversion_done_flag);
  c_dtc_clear:   cover property (dtc_clear);

endmodule

// *** adc_end_flag_control_tb.sv ***
`timescale 1ns/1ns
module adc_end_flag_control_tb;
  // ----
  // signals
  // ----
  localparam int CONV = 8;
  logic        i_mclk = 1'b0;
  logic        i_rst  = 1'b1;
  logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0, data_transfer_controller = 1'b0;
  logic [7:0]  awa = 8'h00, ara = 8'h00;
  logic [31:0] wd  = 32'h0, rd_d, rdat;
  logic [1:0]  rsp, br, rr;
  logic        awr, wrdy, bv, arr, rv, done_irq, irq;
  logic [3:0]  ach, c;
  logic [9:0]  adat;
  int          fail_count = 0, num_checks = 0;
  // reference model of the register state, kept from the rules alone
  int          m_flag = 0, m_ie = 0, m_start = 0, m_scan = 0, m_chan = 0, m_seen = 0;
  int          m_ev = 0;
  int          m_res[$] = '{0, 0, 0, 0};

  // clock and design
  always #10 i_mclk = ~i_mclk;
  afe_model afe (.i_chan(ach), .o_data(adat));
  adc_end_flag_control #(.CONV_CYCLES(CONV)) dut (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_awaddr(awa), .i_awvalid(awv),
    .o_awready(awr), .i_wdata(wd), .i_wstrb(4'hF), .i_wvalid(wv), .o_wready(wrdy),
    .o_bresp(br), .o_bvalid(bv), .i_bready(bry), .i_araddr(ara), .i_arvalid(arv),
    .o_arready(arr), .o_rdata(rdat), .o_rresp(rr), .o_rvalid(rv), .i_rready(rry),
    .i_adc_data(adat), .o_adc_chan(ach), .i_dtc_result_read(data_transfer_controller),
    .o_conversion_done_irq(done_irq), .o_irq(irq));

  // ----
  // tasks
  // ----
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %s exp %h got %h", n, e, g);
    end
  endtask

  task automatic results;
    $display("checks %0d errors %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // a bound that runs out ends the run, so no wait can hang
  task automatic tmo(input int n);
    if (n >= 60) begin
      fail_count++;
      $display("[FAIL] wait exp answer got timeout");
      results;
    end
  endtask

  // write: aw and w offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge i_mclk);
    awa <= a;
    wd  <= d;
    awv <= 1'b1;
    wv  <= 1'b1;
    bry <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (awr) awv <= 1'b0;
      if (wrdy) wv <= 1'b0;
      n++;
    end while (bv !== 1'b1 && n < 60);
    rsp = br;
    bry <= 1'b0;
    tmo(n);
  endtask

  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    @(posedge i_mclk);
    ara <= a;
    arv <= 1'b1;
    rry <= 1'b1;
    do begin
      @(posedge i_mclk);
      if (arr) arv <= 1'b0;
      n++;
    end while (rv !== 1'b1 && n < 60);
    rd_d = rdat;
    rsp  = rr;
    rry <= 1'b0;
    tmo(n);
  endtask

  function automatic logic [31:0] m_csr();
    return 32'(m_flag * 128 + m_ie * 64 + m_start * 32 + m_scan * 16 + m_chan);
  endfunction

  // a finished single channel or group sets the flag and stores results
  task automatic mdone;
    if (m_flag != 0) m_ev = m_ev | 2;
    m_ev    = m_ev | 1;
    m_flag  = 1;
    m_start = m_scan;
    if (m_scan == 0) begin
      m_res[m_chan % 4] = 'h2D0 + m_chan;
    end else begin
      for (int s = 0; s <= m_chan % 4; s++) m_res[s] = 'h2D0 + (m_chan & 12) + s;
    end
  endtask

  // control/status write; the model keeps the read-then-zero clear order
  task automatic wc(input logic [7:0] d);
    wr(8'h00, {24'h0, d});
    chk("bresp", {30'h0, adc_flag_pkg::RESP_OKAY}, {30'h0, rsp});
    if (d[7] == 1'b0 && m_seen != 0) m_flag = 0;
    m_seen  = 0;
    m_ie    = d[6];
    m_start = d[5];
    m_scan  = d[4];
    m_chan  = d[3:0];
  endtask

  task automatic rc;
    rd(8'h00);
    chk("csr", m_csr(), rd_d);
    if (m_flag != 0) m_seen = 1;
  endtask

  task automatic cirq;
    chk("done_irq", 32'(m_flag & m_ie), {31'h0, done_irq});
  endtask

  task automatic wirq;
    int n;
    n = 0;
    while (done_irq !== 1'b1 && n < 60) begin
      @(posedge i_mclk);
      n++;
    end
    tmo(n);
  endtask

  // ----
  // sequence
  // ----
  initial begin
    void'($urandom(32'h164B));
    repeat (20) @(posedge i_mclk);
    i_rst <= 1'b0;
    rc;
    rd(8'h18);
    chk("mask", 32'h0, rd_d);
    rd(8'h1C);
    chk("resp", {30'h0, adc_flag_pkg::RESP_SLVERR}, {30'h0, rsp});
    c = 4'($urandom % 16);
    wc({4'h6, c});
    wirq;
    mdone;
    wc({4'h4, c});
    rc;
    rd(8'h04 + {4'h0, c[1:0], 2'h0});
    chk("result", 32'(m_res[c[1:0]] * 64), rd_d);
    wc({4'h4, c});
    rc;
    cirq;
    // enable off: flag sets but no request
    wc(8'h23);
    repeat (CONV + 8) @(posedge i_mclk);
    mdone;
    cirq;
    rc;
    wc(8'hC3);
    @(posedge i_mclk);
    cirq;
    data_transfer_controller <= 1'b1;
    @(posedge i_mclk);
    data_transfer_controller <= 1'b0;
    if (m_ie != 0) m_flag = 0;
    repeat (2) @(posedge i_mclk);
    cirq;
    rc;
    // scan of four slots: no flag after the first one
    wc(8'h73);
    repeat (CONV + 4) @(posedge i_mclk);
    cirq;
    wirq;
    mdone;
    rc;
    wc(8'h03);
    rc;
    for (int i = 0; i < 4; i++) begin
      rd(8'(4 + 4 * i));
      chk("result", 32'(m_res[i] * 64), rd_d);
    end
    rd(8'h14);
    chk("status", 32'(m_ev), rd_d);
    wr(8'h18, 32'h1);
    @(posedge i_mclk);
    chk("irq", 32'(m_ev & 1), {31'h0, irq});
    wr(8'h14, 32'h1);
    m_ev = m_ev & 2;
    @(posedge i_mclk);
    chk("irq", 32'(m_ev & 1), {31'h0, irq});
    results;
  end
endmodule

// *** adc_flag_pkg.sv ***
package adc_flag_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CSR_OFFSET       = 8'h00;
  localparam logic [7:0] RESULT_OFFSET    = 8'h04;  // four results, one word apart
  localparam logic [7:0] IRQ_STAT_OFFSET  = 8'h14;
  localparam logic [7:0] IRQ_MASK_OFFSET  = 8'h18;

  // ----------------------------------------------------------------
  // control/status field positions
  // ----------------------------------------------------------------
  localparam int FLAG_BIT  = 7;
  localparam int IE_BIT    = 6;
  localparam int START_BIT = 5;
  localparam int SCAN_BIT  = 4;
  localparam int CHAN_LSB  = 0;
  localparam int CHAN_W    = 4;

  // result data sits left aligned in the low half word
  localparam int RES_W     = 10;
  localparam int RES_LSB   = 6;

  // interrupt status bits
  localparam int EV_END_BIT     = 0;  // conversion end flag was set
  localparam int EV_OVERRUN_BIT = 1;  // end arrived while flag still set
  localparam int EV_W           = 2;

  // reset values
  localparam logic [7:0]      CSR_RESET  = 8'h00;
  localparam logic [EV_W-1:0] MASK_RESET = 2'h0;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int CONV_TIME_NS  = 13300;
  localparam int CONV_CYCLES   = (CONV_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // bus answers
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic {SEQ_IDLE, SEQ_CONVERT} seq_state_t;

endpackage

// *** afe_model.sv ***
`timescale 1ns/1ns
module afe_model (
  // channel the mux samples
  input  wire logic [3:0] i_chan,
  // converted value
  output logic [9:0]      o_data
);
  // value tags its channel so a slot mix-up shows at once
  assign o_data = {6'h2D, i_chan};
endmodule

// *** axil_reg_slave.sv ***
`timescale 1ns/1ns
module axil_reg_slave (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_rst,
  // axi4-lite write
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  output logic [1:0]       o_bresp,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  // axi4-lite read
  input  wire logic [7:0]  i_araddr,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  // register side
  reg_access_if.bus        rif
);

  // ----------------------------------------------------------------
  // write and read channel state
  // ----------------------------------------------------------------
  logic        aw_held, next_aw_held;
  logic        w_held, next_w_held;
  logic [7:0]  awaddr, next_awaddr;
  logic [31:0] wdata, next_wdata;
  logic [3:0]  wstrb, next_wstrb;
  logic        bvalid, next_bvalid;
  logic [1:0]  bresp, next_bresp;
  logic        rvalid, next_rvalid;
  logic        awready, next_awready;
  logic        wready, next_wready;
  logic        arready, next_arready;
  logic [31:0] rdata, next_rdata;
  logic [1:0]  rresp, next_rresp;

  // address and data are taken in either order; no new one until b is taken
  always_comb begin
    next_aw_held = aw_held;
    next_w_held  = w_held;
    next_awaddr  = awaddr;
    next_wdata   = wdata;
    next_wstrb   = wstrb;
    next_bvalid  = bvalid;
    next_bresp   = bresp;
    if (i_awvalid && o_awready) begin
      next_aw_held = 1'b1;
      next_awaddr  = i_awaddr;
    end
    if (i_wvalid && o_wready) begin
      next_w_held = 1'b1;
      next_wdata  = i_wdata;
      next_wstrb  = i_wstrb;
    end
    if (rif.wr_en) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = rif.wr_err ? adc_flag_pkg::RESP_SLVERR : adc_flag_pkg::RESP_OKAY;
    end else if (bvalid && i_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // readies are registered copies of their next values, so the top's outputs come from flops
  assign next_awready = !next_aw_held && !next_bvalid;
  assign next_wready  = !next_w_held && !next_bvalid;
  assign next_arready = !next_rvalid;

  // the write fires one edge after both halves are held
  assign rif.wr_en   = aw_held && w_held && !bvalid;
  assign rif.wr_addr = awaddr;
  assign rif.wr_data = wdata;
  assign rif.wr_strb = wstrb;

  // reads are answered on the same edge that takes the address
  always_comb begin
    next_rvalid = rvalid;
    next_rdata  = rdata;
    next_rresp  = rresp;
    if (rif.rd_en) begin
      next_rvalid = 1'b1;
      next_rdata  = rif.rd_data;
      next_rresp  = rif.rd_err ? adc_flag_pkg::RESP_SLVERR : adc_flag_pkg::RESP_OKAY;
    end else if (rvalid && i_rready) begin
      next_rvalid = 1'b0;
    end
  end

  assign rif.rd_en   = i_arvalid && o_arready;
  assign rif.rd_addr = i_araddr;

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      aw_held <= 1'b0;
      w_held  <= 1'b0;
      awaddr  <= 8'h00;
      wdata   <= 32'h00000000;
      wstrb   <= 4'h0;
      bvalid  <= 1'b0;
      bresp   <= 2'h0;
      rvalid  <= 1'b0;
      rdata   <= 32'h00000000;
      rresp   <= 2'h0;
      awready <= 1'b1;
      wready  <= 1'b1;
      arready <= 1'b1;
    end else begin
      aw_held <= next_aw_held;
      w_held  <= next_w_held;
      awaddr  <= next_awaddr;
      wdata   <= next_wdata;
      wstrb   <= next_wstrb;
      bvalid  <= next_bvalid;
      bresp   <= next_bresp;
      rvalid  <= next_rvalid;
      rdata   <= next_rdata;
      rresp   <= next_rresp;
      awready <= next_awready;
      wready  <= next_wready;
      arready <= next_arready;
    end
  end

  assign o_awready = awready;
  assign o_wready  = wready;
  assign o_bvalid  = bvalid;
  assign o_bresp   = bresp;
  assign o_arready = arready;
  assign o_rvalid  = rvalid;
  assign o_rdata   = rdata;
  assign o_rresp   = rresp;

endmodule

// *** conv_sequencer.sv ***
`timescale 1ns/1ns
module conv_sequencer #(
  parameter int CONV_CYCLES = adc_flag_pkg::CONV_CYCLES
) (
  // clock and reset
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  // control
  input  wire logic       i_start,
  input  wire logic       i_scan,
  input  wire logic [3:0] i_chan,
  // progress
  output logic            o_ch_done,
  output logic            o_all_done,
  output logic [1:0]      o_slot,
  output logic            o_busy
);

  localparam int CNT_W = $clog2(CONV_CYCLES + 1);
  localparam logic [CNT_W-1:0] LAST = CNT_W'(CONV_CYCLES - 1);

  adc_flag_pkg::seq_state_t state, next_state;
  logic [CNT_W-1:0]         cnt, next_cnt;
  logic [1:0]               slot, next_slot;

  // one conversion per slot; scan walks slots 0..chan[1:0] and wraps
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_slot  = slot;
    o_ch_done  = 1'b0;
    o_all_done = 1'b0;
    unique case (state)
      adc_flag_pkg::SEQ_IDLE: begin
        if (i_start) begin
          next_state = adc_flag_pkg::SEQ_CONVERT;
          next_cnt   = '0;
          next_slot  = i_scan ? 2'h0 : i_chan[1:0];
        end
      end
      adc_flag_pkg::SEQ_CONVERT: begin
        if (!i_start) begin
          // clearing start abandons the conversion in flight
          next_state = adc_flag_pkg::SEQ_IDLE;
        end else if (cnt == LAST) begin
          o_ch_done = 1'b1;
          next_cnt  = '0;
          if (!i_scan) begin
            o_all_done = 1'b1;
            next_state = adc_flag_pkg::SEQ_IDLE;
          end else if (slot == i_chan[1:0]) begin
            o_all_done = 1'b1;
            next_slot  = 2'h0;
          end else begin
            next_slot = slot + 2'h1;
          end
        end else begin
          next_cnt = cnt + CNT_W'(1);
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk or posedge i_rst) begin
    if (i_rst) begin
      state <= adc_flag_pkg::SEQ_IDLE;
      cnt   <= '0;
      slot  <= 2'h0;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
      slot  <= next_slot;
    end
  end

  assign o_slot = slot;
  assign o_busy = (state == adc_flag_pkg::SEQ_CONVERT);

  // a scan ends only on the last slot of the group
  a_scan_group_end: assert property (@(posedge i_mclk) disable iff (i_rst)
    o_all_done && i_scan |-> slot == i_chan[1:0])
    else $error("scan ended before last channel");

endmodule

// *** reg_access_if.sv ***
`timescale 1ns/1ns
// register access strobes between the bus slave and the register file
interface reg_access_if;
  logic        wr_en;
  logic [7:0]  wr_addr;
  logic [31:0] wr_data;
  logic [3:0]  wr_strb;
  logic        wr_err;
  logic        rd_en;
  logic [7:0]  rd_addr;
  logic [31:0] rd_data;
  logic        rd_err;

  modport bus  (output wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                input  wr_err, rd_data, rd_err);
  modport regs (input  wr_en, wr_addr, wr_data, wr_strb, rd_en, rd_addr,
                output wr_err, rd_data, rd_err);
endinterface
